// ==== logic/nsc_params.svh ====
// Constants for the nanobit successor and shift control block.
// Assumes inclusion by bare name from the logic/ folder.
// Functional notes
// - Polarity bit picks condition level; type two blocks
// - True, false, or step-by-one successor select
// - Qualify bit gates operations on successor condition
// - Type two suppresses operation and adjust enables
// - Enables routed to operations and adjust circuits
// - Shift control held in five flip-flops
// - Amount field: hold, complement, load barrel bits
// - Select 00 none, 01 right zero fill
// - Left shift needs complemented count; all right
// - Select 11 right circular by count
// - Count sampled at start of phase three
// - Left enable for left and circular shifts
// - Right enable high except left shift
// - Shift active whenever a shift is selected
// - Save sign: first end bit to saved sign
// - Prior saved sign forced into opposite end
// - No save sign: store end bit, no force
// - Save sign, no shift: store top carry
// - No save sign, no shift: hold saved sign
// - Condition adjust applied at end of phase one
// - Carry flag from previous microinstruction's adder
// - Phase three inhibited: type two or unmet conditional logic unit op
`ifndef NSC_PARAMS_SVH
`define NSC_PARAMS_SVH

`define NSC_ADDR_W        4
`define NSC_DATA_W        16
`define NSC_OFF_CTRL      4'h0
`define NSC_OFF_STATUS    4'h4
`define NSC_CTRL_ADJ_BLK  0
`define NSC_CTRL_EXT_BLK  1
`define NSC_CTRL_RESET    2'h0
`define NSC_AMOUNT_W      4
`define NSC_AMOUNT_RESET  4'h0
`define NSC_FLOPS_RESET   6'h00

`endif

// ==== logic/nsc_pkg.sv ====
// Types shared by the nanobit successor and shift control block.
// Assumes no other package.
`default_nettype none
package nsc_pkg;
  typedef enum logic [1:0] {
    NSC_SH_NONE  = 2'h0,
    NSC_SH_RIGHT = 2'h1,
    NSC_SH_LEFT  = 2'h2,
    NSC_SH_CIRC  = 2'h3
  } nsc_shift_sel_t;

  typedef enum logic [1:0] {
    NSC_AM_HOLD = 2'h0,
    NSC_AM_CMPL = 2'h1,
    NSC_AM_LOAD = 2'h2,
    NSC_AM_RSVD = 2'h3
  } nsc_amount_sel_t;

  // Gray along idle -> phase one -> phase three -> phase one
  typedef enum logic [1:0] {
    NSC_PH_IDLE  = 2'h0,
    NSC_PH_ONE   = 2'h1,
    NSC_PH_THREE = 2'h3
  } nsc_phase_t;
endpackage
`default_nettype wire

// ==== logic/nsc_amount_reg.sv ====
// Shift amount register: hold, complement or parallel load.
// Assumes one-cycle update strobe from the shift control logic.
`default_nettype none
`include "nsc_params.svh"
module nsc_amount_reg #(
  parameter int W = `NSC_AMOUNT_W
) (
  input  wire logic         clk,       // System clock
  input  wire logic         rst,       // Synchronous reset
  input  wire logic         ce,        // Clock enable
  input  wire logic         upd,       // Update strobe
  input  wire logic         load,      // Take barrel bits
  input  wire logic         cmpl,      // Complement contents
  input  wire logic [W-1:0] bsw_bits,  // Low barrel switch bits
  output logic      [W-1:0] amount_q   // Register contents
);
  always_ff @(posedge clk) begin
    if (rst) begin
      amount_q <= '0;
    end else if (ce && upd) begin
      if (load) begin
        amount_q <= bsw_bits;
      end else if (cmpl) begin
        amount_q <= ~amount_q;
      end
    end
  end
endmodule
`default_nettype wire

// ==== logic/nsc_ctrl.sv ====
// Successor, external operation gating and shift control flops.
// Assumes phase strobes and nanobits synchronous to clk.
//
// Added by the designer: the strobed register port and the register addresses.
`default_nettype none
`include "nsc_params.svh"
module nsc_ctrl #(
  parameter int AW = `NSC_AMOUNT_W
) (
  input  wire logic                   clk,                       // System clock
  input  wire logic                   rst,                       // Synchronous reset
  input  wire logic                   ce,                        // Clock enable
  input  wire logic                   phase1_end,                // End of phase one
  input  wire logic                   phase3_clk,                // Phase three request
  input  wire logic                   selected_condition,        // Condition under test
  input  wire logic                   successor_polarity_bit,    // Test level nanobit
  input  wire logic                   ext_op_qualify_bit,        // Qualify nanobit
  input  wire logic                   type_two_microinstruction, // Type two level
  input  wire logic                   false_successor_coded,     // False successor present
  input  wire logic                   lu_conditional,            // Conditional logic unit op
  input  wire logic                   amount_load_bit_hi,        // Amount field high
  input  wire logic                   amount_load_bit_lo,        // Amount field low
  input  wire logic                   shift_select_bit_hi,       // Select field high
  input  wire logic                   shift_select_bit_lo,       // Select field low
  input  wire logic                   save_sign_bit_select,      // Save sign nanobit
  input  wire logic [AW-1:0]          barrel_switch_low,         // Low barrel bits
  input  wire logic                   adder_low_bit,             // Adder LSB
  input  wire logic                   adder_high_bit,            // Adder MSB
  input  wire logic                   adder_top_carry,           // Adder MSB carry
  input  wire logic [`NSC_ADDR_W-1:0] reg_addr,                  // Register address
  input  wire logic [`NSC_DATA_W-1:0] reg_wdata,                 // Write data
  input  wire logic                   reg_wr,                    // Write strobe
  input  wire logic                   reg_rd,                    // Read strobe
  output logic      [`NSC_DATA_W-1:0] reg_rdata,                 // Read data
  output logic                        successor_condition,       // Condition met
  output logic                        successor_condition_n,     // Condition not met
  output logic                        take_true_successor,       // True successor
  output logic                        take_false_successor,      // False successor
  output logic                        step_micro_pc,             // Step counter by one
  output logic                        external_op_enable,        // Memory/device op enable
  output logic                        adjust_enable,             // Adjust enable
  output logic                        condition_adjust,          // Adjust strobe
  output logic                        phase3_inhibit,            // Phase three inhibited
  output logic                        phase3_exec,               // Phase three executes
  output logic      [AW-1:0]          shift_amount_reg,          // Shift count
  output logic                        left_shift_enable,         // To barrel switch
  output logic                        right_shift_enable,        // To barrel switch
  output logic                        shift_active,              // To amount out select
  output logic                        force_low_end_bit,         // Force barrel LSB
  output logic                        force_high_end_bit,        // Force barrel MSB
  output logic                        force_value,               // Bit being forced
  output logic                        saved_sign_flop,           // Saved sign
  output logic                        adder_carry_out_flag       // Previous top carry
);
  nsc_pkg::nsc_phase_t      phase_q;
  nsc_pkg::nsc_phase_t      phase_d;
  nsc_pkg::nsc_shift_sel_t  sel;
  logic                     load_bsw_q;
  logic                     cmpl_amount_q;
  logic                     shift_right_q;
  logic                     shift_left_q;
  logic                     save_sign_control_q;
  logic                     saved_sign_q;
  logic                     carry_flag_q;
  logic [1:0]               ctrl_q;
  logic [`NSC_DATA_W-1:0]   rdata_q;
  logic                     cond_met;
  logic                     sh_exec;
  logic                     end_off;

  // Level match of the tested condition, before the type two block
  assign cond_met = successor_polarity_bit ? selected_condition
                                           : ~selected_condition;

  assign successor_condition   = cond_met & ~type_two_microinstruction;
  assign successor_condition_n = ~cond_met & ~type_two_microinstruction;

  // True successor is always present in a conditional microinstruction
  assign take_true_successor  = successor_condition;
  assign take_false_successor = successor_condition_n & false_successor_coded;
  assign step_micro_pc        = successor_condition_n & ~false_successor_coded;

  // Both enables share the type two and qualify terms; only the external op enable also has a control block bit; type two kills both
  assign external_op_enable = ~type_two_microinstruction
                            & ~ctrl_q[`NSC_CTRL_EXT_BLK]
                            & (~ext_op_qualify_bit | cond_met);
  assign adjust_enable      = ~type_two_microinstruction
                            & (~ext_op_qualify_bit | cond_met);

  // Adjust pulse lands at the end of phase one only
  assign condition_adjust = ce & phase1_end & adjust_enable
                          & external_op_enable
                          & ~ctrl_q[`NSC_CTRL_ADJ_BLK];

  assign phase3_inhibit = type_two_microinstruction
                        | (lu_conditional & ~cond_met);
  assign phase3_exec    = ce & phase3_clk & ~phase3_inhibit
                        & (phase_q == nsc_pkg::NSC_PH_ONE);

  always_comb begin
    phase_d = phase_q;
    case (phase_q)
      nsc_pkg::NSC_PH_IDLE: begin
        if (phase1_end) begin
          phase_d = nsc_pkg::NSC_PH_ONE;
        end
      end
      nsc_pkg::NSC_PH_ONE: begin
        if (phase3_clk) begin
          phase_d = nsc_pkg::NSC_PH_THREE;
        end
      end
      nsc_pkg::NSC_PH_THREE: begin
        if (phase1_end) begin
          phase_d = nsc_pkg::NSC_PH_ONE;
        end
      end
      default: begin
        phase_d = nsc_pkg::NSC_PH_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      phase_q <= nsc_pkg::NSC_PH_IDLE;
    end else if (ce) begin
      phase_q <= phase_d;
    end
  end

  // Five shift control flops load from the nanobits at end of phase one
  always_ff @(posedge clk) begin
    if (rst) begin
      {load_bsw_q, cmpl_amount_q, shift_right_q,
       shift_left_q, save_sign_control_q} <= 5'h0;
    end else if (ce && phase1_end) begin
      load_bsw_q          <= amount_load_bit_hi & ~amount_load_bit_lo;
      cmpl_amount_q       <= ~amount_load_bit_hi & amount_load_bit_lo;
      shift_right_q       <= shift_select_bit_lo;
      shift_left_q        <= shift_select_bit_hi;
      save_sign_control_q <= save_sign_bit_select;
    end
  end

  assign sel = nsc_pkg::nsc_shift_sel_t'({shift_left_q, shift_right_q});

  // Barrel switch only shifts right; left shifts use a complemented count
  assign left_shift_enable  = shift_left_q;
  assign right_shift_enable = (sel != nsc_pkg::NSC_SH_LEFT);
  assign shift_active       = (sel != nsc_pkg::NSC_SH_NONE);
  assign sh_exec            = phase3_exec & shift_active;
  assign end_off            = (sel == nsc_pkg::NSC_SH_RIGHT)
                            | (sel == nsc_pkg::NSC_SH_LEFT);

  // Register read is sampled before the phase three update takes place
  nsc_amount_reg #(
    .W (AW)
  ) u_amount (
    .clk      (clk),
    .rst      (rst),
    .ce       (ce),
    .upd      (phase3_exec),
    .load     (load_bsw_q),
    .cmpl     (cmpl_amount_q),
    .bsw_bits (barrel_switch_low),
    .amount_q (shift_amount_reg)
  );

  // Circular shifts wrap their own end bits, so no force is generated
  assign force_high_end_bit = save_sign_control_q & phase3_exec
                            & (sel == nsc_pkg::NSC_SH_RIGHT);
  assign force_low_end_bit  = save_sign_control_q & phase3_exec
                            & (sel == nsc_pkg::NSC_SH_LEFT);
  assign force_value        = saved_sign_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      saved_sign_q <= 1'b0;
    end else if (ce) begin
      if (sh_exec) begin
        saved_sign_q <= (adder_low_bit & shift_right_q)
                      | (adder_high_bit & shift_left_q);
      end else if (phase3_exec && save_sign_control_q) begin
        saved_sign_q <= adder_top_carry;
      end
    end
  end // otherwise held
  assign saved_sign_flop = saved_sign_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      carry_flag_q <= 1'b0;
    end else if (ce && phase3_exec) begin
      carry_flag_q <= adder_top_carry;
    end
  end
  assign adder_carry_out_flag = carry_flag_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_q <= `NSC_CTRL_RESET;
    end else if (ce && reg_wr && reg_addr == `NSC_OFF_CTRL) begin
      ctrl_q <= reg_wdata[1:0];
    end
  end

  // Unmapped addresses read as zero
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_q <= '0;
    end else if (ce) begin
      rdata_q <= '0;
      if (reg_rd && reg_addr == `NSC_OFF_CTRL) begin
        rdata_q <= {14'h0000, ctrl_q};
      end else if (reg_rd && reg_addr == `NSC_OFF_STATUS) begin
        rdata_q <= {1'b0, phase_q, carry_flag_q, 4'(shift_amount_reg),
                    2'h0, save_sign_control_q, saved_sign_q,
                    shift_left_q, shift_right_q, cmpl_amount_q, load_bsw_q};
      end
    end
  end
  assign reg_rdata = rdata_q;
endmodule
`default_nettype wire

// ==== tb/nsc_ctrl_properties.sv ====
// Concurrent checks on the successor and shift control ports.
// Assumes binding into nsc_ctrl, one clock, synchronous high reset.
`default_nettype none
module nsc_ctrl_properties (
  input wire logic clk,                       // Clock
  input wire logic rst,                       // Reset
  input wire logic ce,                        // Enable
  input wire logic phase1_end,                // Phase one end
  input wire logic selected_condition,        // Condition
  input wire logic successor_polarity_bit,    // Polarity
  input wire logic ext_op_qualify_bit,        // Qualify
  input wire logic type_two_microinstruction, // Type two
  input wire logic shift_select_bit_hi,       // Select high
  input wire logic shift_select_bit_lo,       // Select low
  input wire logic adder_top_carry,           // Adder carry
  input wire logic successor_condition,       // Condition met
  input wire logic adjust_enable,             // Adjust enable
  input wire logic phase3_inhibit,            // Inhibit
  input wire logic phase3_exec,               // Execute
  input wire logic left_shift_enable,         // Left enable
  input wire logic right_shift_enable,        // Right enable
  input wire logic shift_active,              // Shift active
  input wire logic force_low_end_bit,         // Force low
  input wire logic force_high_end_bit,        // Force high
  input wire logic adder_carry_out_flag       // Carry flag
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk);
  endclocking
  a_succ_level: assert property (disable iff (rst)
    successor_condition == (!type_two_microinstruction &&
    successor_polarity_bit == selected_condition)) else $error("successor level wrong");
  a_adjust_gate: assert property (disable iff (rst)
    adjust_enable == (!type_two_microinstruction && (!ext_op_qualify_bit ||
    successor_condition))) else $error("adjust enable wrong");
  a_exec_gate: assert property (disable iff (rst)
    phase3_exec |-> !phase3_inhibit && !type_two_microinstruction)
    else $error("phase three ran while inhibited");
  a_left_decode: assert property (disable iff (rst)
    ce && phase1_end |=> left_shift_enable == $past(shift_select_bit_hi))
    else $error("left enable wrong");
  a_right_decode: assert property (disable iff (rst)
    ce && phase1_end |=> right_shift_enable ==
    !$past(shift_select_bit_hi && !shift_select_bit_lo)) else $error("right enable wrong");
  a_active_decode: assert property (disable iff (rst)
    ce && phase1_end |=> shift_active == $past(shift_select_bit_hi || shift_select_bit_lo))
    else $error("shift active wrong");
  a_force_only_exec: assert property (disable iff (rst)
    force_low_end_bit || force_high_end_bit |-> phase3_exec && shift_active)
    else $error("end force outside a shift");
  a_carry_flag: assert property (disable iff (rst)
    phase3_exec |=> adder_carry_out_flag == $past(adder_top_carry))
    else $error("carry flag wrong");
endmodule
bind nsc_ctrl nsc_ctrl_properties u_props (.*);
`default_nettype wire

// ==== tb/nsc_far_model.sv ====
// Far-side model: adder result bits and low barrel switch bits.
// Assumes the bench sets the adder word and carry per microinstruction.
`default_nettype none
module nsc_far_model (
  input  wire logic [15:0] word,                // Adder result
  input  wire logic        carry,               // Adder top carry
  input  wire logic        shift_select_bit_hi, // Select high
  input  wire logic        shift_select_bit_lo, // Select low
  output logic      [3:0]  barrel_switch_low,   // Low barrel bits
  output logic             adder_low_bit,       // Result LSB
  output logic             adder_high_bit,      // Result MSB
  output logic             adder_top_carry      // Result carry
);
  timeunit 1ns;
  timeprecision 1ns;
  // Every shift runs right, so a left count arrives complemented
  assign barrel_switch_low = (shift_select_bit_hi && !shift_select_bit_lo) ?
                             ~word[3:0] : word[3:0];
  assign {adder_high_bit, adder_low_bit, adder_top_carry} = {word[15], word[0], carry};
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench for the successor and shift control block.
// Assumes the far-side model supplies adder and barrel bits.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, ce, phase1_end, phase3_clk, selected_condition, successor_polarity_bit;
  logic ext_op_qualify_bit, type_two_microinstruction, false_successor_coded, lu_conditional;
  logic amount_load_bit_hi, amount_load_bit_lo, shift_select_bit_hi, shift_select_bit_lo;
  logic save_sign_bit_select, adder_low_bit, adder_high_bit, adder_top_carry, reg_wr, reg_rd;
  logic successor_condition, successor_condition_n, take_true_successor, take_false_successor;
  logic step_micro_pc, external_op_enable, adjust_enable, condition_adjust, phase3_inhibit;
  logic phase3_exec, left_shift_enable, right_shift_enable, shift_active, force_low_end_bit;
  logic force_high_end_bit, force_value, saved_sign_flop, adder_carry_out_flag, carry;
  logic [3:0]  barrel_switch_low, shift_amount_reg, reg_addr;
  logic [15:0] reg_wdata, reg_rdata, word;
  logic        prev_es;
  int          error_cnt, n_checks;
  nsc_ctrl DUT (.*);
  nsc_far_model u_far (.*);
  always #50 clk = ~clk;
  task automatic chk(input logic [15:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    $display("checks=%0d mismatches=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic t_successor;
    logic sc, scn, ae;
    for (int i = 0; i < 64; i++) begin
      @(posedge clk);
      {type_two_microinstruction, successor_polarity_bit, selected_condition,
       ext_op_qualify_bit, false_successor_coded, lu_conditional} <= 6'(i);
      @(negedge clk);
      sc = !type_two_microinstruction && (successor_polarity_bit == selected_condition);
      scn = !type_two_microinstruction && !sc;
      ae = !type_two_microinstruction && (!ext_op_qualify_bit || sc);
      chk(16'({successor_condition, successor_condition_n}), 16'({sc, scn}));
      chk(16'({take_true_successor, take_false_successor, step_micro_pc}), 16'({sc,
          scn && false_successor_coded, scn && !false_successor_coded}));
      chk(16'({adjust_enable, external_op_enable}), 16'({ae, ae}));
      chk(16'(phase3_inhibit), 16'(type_two_microinstruction || (lu_conditional && !sc)));
    end
  endtask
  // One full microinstruction: phase one latch, then an executed phase three
  task automatic micro(input logic [1:0] sel, amt, input logic save_sign_control, cy,
                       input logic [15:0] w, input logic [1:0] ef, input logic es,
                       input logic [3:0] ea);
    @(posedge clk);
    {shift_select_bit_hi, shift_select_bit_lo} <= sel;
    {amount_load_bit_hi, amount_load_bit_lo}   <= amt;
    {save_sign_bit_select, carry, type_two_microinstruction, lu_conditional} <= {save_sign_control, cy, 2'h0};
    word <= w;
    phase1_end <= 1'b1;
    @(posedge clk);
    phase1_end <= 1'b0;
    @(negedge clk);
    chk(16'({left_shift_enable, right_shift_enable, shift_active}),
        16'({sel[1], sel != 2'h2, sel != 2'h0}));
    @(posedge clk);
    phase3_clk <= 1'b1;
    @(negedge clk);
    chk(16'({force_high_end_bit, force_low_end_bit, force_value, phase3_exec}),
        16'({ef, prev_es, 1'b1}));
    @(posedge clk);
    phase3_clk <= 1'b0;
    @(negedge clk);
    chk(16'({saved_sign_flop, adder_carry_out_flag, shift_amount_reg}), 16'({es, cy, ea}));
    prev_es = es;
  endtask
  task automatic t_shift;
    micro(2'h0, 2'h2, 1'b0, 1'b0, 16'h000A, 2'h0, 1'b0, 4'hA);
    micro(2'h0, 2'h1, 1'b0, 1'b0, 16'h0000, 2'h0, 1'b0, 4'h5);
    micro(2'h0, 2'h0, 1'b0, 1'b0, 16'h0000, 2'h0, 1'b0, 4'h5);
    micro(2'h1, 2'h0, 1'b1, 1'b0, 16'h0001, 2'h2, 1'b1, 4'h5);
    micro(2'h2, 2'h2, 1'b1, 1'b0, 16'h0003, 2'h1, 1'b0, 4'hC);
    micro(2'h3, 2'h0, 1'b0, 1'b0, 16'h8000, 2'h0, 1'b1, 4'hC);
    micro(2'h0, 2'h0, 1'b1, 1'b0, 16'h0000, 2'h0, 1'b0, 4'hC);
    micro(2'h0, 2'h0, 1'b0, 1'b1, 16'h0000, 2'h0, 1'b0, 4'hC);
    micro(2'h1, 2'h0, 1'b0, 1'b0, 16'h0001, 2'h0, 1'b1, 4'hC);
  endtask
  // Conditional logic unit op with an unmet condition must not run phase three
  task automatic t_inhibit;
    @(posedge clk);
    {phase1_end, lu_conditional, selected_condition} <= 3'h6;
    @(posedge clk);
    {phase1_end, phase3_clk} <= 2'h1;
    @(negedge clk);
    chk(16'({phase3_inhibit, phase3_exec}), 16'h0002);
    @(posedge clk);
    {phase3_clk, lu_conditional, selected_condition} <= 3'h1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk(reg_rdata, e);
  endtask
  task automatic adj(input logic e);
    @(posedge clk);
    phase1_end <= 1'b1;
    @(negedge clk);
    chk(16'(condition_adjust), 16'(e));
    @(posedge clk);
    phase1_end <= 1'b0;
  endtask
  task automatic t_regs;
    rd(4'h4, 16'h6C14);
    rd(4'h8, 16'h0000);
    wr(4'h0, 16'h0002);
    @(negedge clk);
    chk(16'({external_op_enable, adjust_enable}), 16'h0001);
    wr(4'h0, 16'h0001);
    adj(1'b0);
    wr(4'h0, 16'h0000);
    @(posedge clk);
    ce <= 1'b0;
    adj(1'b0);
    ce <= 1'b1;
    adj(1'b1);
  endtask
  initial begin
    {clk, phase1_end, phase3_clk, selected_condition, successor_polarity_bit, ext_op_qualify_bit,
     type_two_microinstruction, false_successor_coded, lu_conditional, amount_load_bit_hi,
     amount_load_bit_lo, shift_select_bit_hi, shift_select_bit_lo, save_sign_bit_select,
     reg_wr, reg_rd, reg_addr, reg_wdata, word, carry, prev_es} = '0;
    {rst, ce} = 2'h3;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk(16'({shift_amount_reg, shift_active, left_shift_enable, right_shift_enable,
        saved_sign_flop}), 16'h0002);
    t_successor();
    t_shift();
    t_inhibit();
    t_regs();
    test_done();
  end
  initial begin
    repeat (2000) @(posedge clk);
    error_cnt++;
    test_done();
  end
endmodule
`default_nettype wire
